/* core/charger_control_defines.vh */
// Offsets, field positions, reset values and timing counts of the charger control registers.
`ifndef CHARGER_CONTROL_DEFINES_VH
`define CHARGER_CONTROL_DEFINES_VH
`define CHG_CTRL_ONE_ADDR 8'h37
`define FAST_CHG_ADDR 8'h38
`define FINISH_CTRL_ADDR 8'h39
`define CHG_CTRL_ONE_RESET 8'h44
`define FAST_CHG_RESET 8'h46
`define FINISH_CTRL_RESET 8'h63
`define FINISH_CTRL_RSVD_MASK 8'hE7
`define LOCK_KEY_MSB 1
`define LOCK_KEY_LSB 0
`define LOCK_KEY_OPEN 2'h3
`define BUCK_ENABLE_BIT 2
`define TEMP_PROFILE_BIT 3
`define THERMISTOR_DIS_BIT 4
`define GLITCH_EN_BIT 5
`define GLITCH_TIME_MSB 7
`define GLITCH_TIME_LSB 6
`define FCC_MSB 4
`define FCC_LSB 0
`define FCT_MSB 7
`define FCT_LSB 5
`define FINISH_THR_MSB 2
`define FINISH_THR_LSB 0
`define FINISH_TIME_MSB 7
`define FINISH_TIME_LSB 5
`define CLK_FREQ_HZ 25000000
`define GLITCH_STEP_MS 8'h32
`define MS_CYCLES (`CLK_FREQ_HZ / 1000)
`endif

/* core/ldo_glitch_filter.v */
// Falling-edge hold-off timer that keeps the safe-output regulator on through short supply dips.
`timescale 1ns/1ns
`include "charger_control_defines.vh"
module ldo_glitch_filter #(
  parameter [31:0] MS_CYCLES = `MS_CYCLES
) (
  input wire ref_clk_i, // System clock.
  input wire srst_i, // Synchronous reset, active high.
  input wire supply_valid_i, // Synchronised input-valid level.
  input wire filter_enable_i, // Hold-off timer enable.
  input wire [1:0] filter_time_i, // Hold-off duration code.
  output reg ldo_enable_o // Safe-output regulator enable.
);
  reg [31:0] tick_cnt_reg;
  reg [7:0] ms_cnt_reg;
  wire [7:0] limit_ms;
  wire ms_tick;

  // Duration is 50 ms times one plus the code.
  assign limit_ms = {4'h0, 2'h0, filter_time_i} * `GLITCH_STEP_MS + `GLITCH_STEP_MS;
  assign ms_tick = (tick_cnt_reg == MS_CYCLES - 32'h1);

  // Millisecond enable and hold-off counter run only while the input is missing.
  always @(posedge ref_clk_i) begin
    if (srst_i || supply_valid_i) begin
      tick_cnt_reg <= 32'h0;
      ms_cnt_reg <= 8'h0;
    end else if (ms_tick) begin
      tick_cnt_reg <= 32'h0;
      if (ms_cnt_reg != 8'hFF)
        ms_cnt_reg <= ms_cnt_reg + 8'h1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  // Rising input enables at once; a fall disables after the hold-off expires, or at once while the timer is disabled.
  always @(posedge ref_clk_i) begin
    if (srst_i)
      ldo_enable_o <= 1'b0;
    else if (supply_valid_i)
      ldo_enable_o <= 1'b1;
    else if (!filter_enable_i)
      ldo_enable_o <= 1'b0;
    else if (ms_cnt_reg >= limit_ms)
      ldo_enable_o <= 1'b0;
  end
endmodule // ldo_glitch_filter

/* core/charger_control_registers.v */
// Charger control register bank with settings lock and safe-output regulator hold-off.
//
// Behaviour
// - Lock key value 11 unlocks protected settings; other values lock; resets locked.
// - Fast-charge and finish registers accept writes only while unlocked.
// - Bit 2 enables the step-down converter; resets enabled.
// - Bit 3 zero enables temperature profile; extreme thresholds always sensed.
// - Bit 4 set disables thermistor monitoring; resets cleared.
// - Bit 5 enables regulator hold-off timer; resets disabled.
// - With timer enabled, regulator stays on through dips shorter than hold-off.
// - Hold-off only on falling input; rising valid input enables regulator immediately.
// - Bits 7:6 select 50, 100, 150 or 200 ms; reset 100 ms.
// - Five-bit code sets fast-charge current limit while charging enabled.
// - Three-bit timeout: 000 off, 4 to 9 hours, 111 sixteen hours.
// - Three-bit finish threshold 50 to 400 mA starts finish timer.
// - Finish timer 0 to 60 minutes; code 111 disables, never done.
`timescale 1ns/1ns
`include "charger_control_defines.vh"
module charger_control_registers (
  input wire ref_clk_i, // System clock, 25 MHz.
  input wire srst_i, // Synchronous reset, active high.
  input wire wr_en_i, // Register write strobe.
  input wire rd_en_i, // Register read strobe.
  input wire [7:0] addr_i, // Register address.
  input wire [7:0] wdata_i, // Write data.
  input wire charger_enable_i, // Charging enabled by the charger core.
  input wire charger_input_supply_i, // Input-valid level from the supply comparator pin.
  output reg [7:0] rdata_o, // Read data, registered.
  output reg rvalid_o, // Read data valid pulse.
  output reg settings_unlocked_o, // Protected settings writable.
  output reg buck_enable_o, // Step-down converter enable.
  output reg temperature_profile_enable_o, // Temperature profile active.
  output reg thermistor_enable_o, // Thermistor monitoring active.
  output reg ldo_enable_o, // Safe-output regulator enable.
  output reg [4:0] fast_charge_current_code_o, // Current limit code applied to the loop.
  output reg [2:0] fast_charge_timeout_o, // Fast-charge timeout code.
  output reg fast_charge_timer_enable_o, // Fast-charge timer active.
  output reg [2:0] finish_current_threshold_o, // Finish-current threshold code.
  output reg [2:0] finish_timer_duration_o, // Finish timer code.
  output reg finish_timer_enable_o // Finish timer active; low means never done.
);
  reg [7:0] ctrl_one_reg;
  reg [7:0] fast_chg_reg;
  reg [7:0] finish_reg;
  reg [2:0] supply_sync_reg;
  reg supply_valid_reg;
  reg [7:0] rdata_next;
  wire unlocked;
  wire ldo_enable;

  assign unlocked = (ctrl_one_reg[`LOCK_KEY_MSB:`LOCK_KEY_LSB] == `LOCK_KEY_OPEN);

  // Register writes; protected registers only take data while unlocked.
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl_one_reg <= `CHG_CTRL_ONE_RESET;
      fast_chg_reg <= `FAST_CHG_RESET;
      finish_reg <= `FINISH_CTRL_RESET;
    end else if (wr_en_i) begin
      if (addr_i == `CHG_CTRL_ONE_ADDR)
        ctrl_one_reg <= wdata_i;
      if (addr_i == `FAST_CHG_ADDR && unlocked)
        fast_chg_reg <= wdata_i;
      if (addr_i == `FINISH_CTRL_ADDR && unlocked)
        finish_reg <= wdata_i & `FINISH_CTRL_RSVD_MASK;
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always @* begin
    case (addr_i)
      `CHG_CTRL_ONE_ADDR: rdata_next = ctrl_one_reg;
      `FAST_CHG_ADDR: rdata_next = fast_chg_reg;
      `FINISH_CTRL_ADDR: rdata_next = finish_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i)
        rdata_o <= rdata_next;
    end
  end

  // Three-stage synchroniser; a change counts once stages two and three agree.
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      supply_sync_reg <= 3'h0;
      supply_valid_reg <= 1'b0;
    end else begin
      supply_sync_reg <= {supply_sync_reg[1:0], charger_input_supply_i};
      if (supply_sync_reg[1] == supply_sync_reg[2])
        supply_valid_reg <= supply_sync_reg[2];
    end
  end

  ldo_glitch_filter u_glitch (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .supply_valid_i(supply_valid_reg),
    .filter_enable_i(ctrl_one_reg[`GLITCH_EN_BIT]),
    .filter_time_i(ctrl_one_reg[`GLITCH_TIME_MSB:`GLITCH_TIME_LSB]),
    .ldo_enable_o(ldo_enable)
  );

  // Decoded controls, each registered.
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      settings_unlocked_o <= 1'b0;
      buck_enable_o <= 1'b1;
      temperature_profile_enable_o <= 1'b1;
      thermistor_enable_o <= 1'b1;
      ldo_enable_o <= 1'b0;
      fast_charge_current_code_o <= 5'h00;
      fast_charge_timeout_o <= 3'h2;
      fast_charge_timer_enable_o <= 1'b1;
      finish_current_threshold_o <= 3'h3;
      finish_timer_duration_o <= 3'h3;
      finish_timer_enable_o <= 1'b1;
    end else begin
      settings_unlocked_o <= unlocked;
      buck_enable_o <= ctrl_one_reg[`BUCK_ENABLE_BIT];
      temperature_profile_enable_o <= ~ctrl_one_reg[`TEMP_PROFILE_BIT];
      thermistor_enable_o <= ~ctrl_one_reg[`THERMISTOR_DIS_BIT];
      ldo_enable_o <= ldo_enable;
      // Current code is only applied while charging; otherwise zero current.
      fast_charge_current_code_o <= charger_enable_i ? fast_chg_reg[`FCC_MSB:`FCC_LSB] : 5'h00;
      fast_charge_timeout_o <= fast_chg_reg[`FCT_MSB:`FCT_LSB];
      fast_charge_timer_enable_o <= (fast_chg_reg[`FCT_MSB:`FCT_LSB] != 3'h0);
      finish_current_threshold_o <= finish_reg[`FINISH_THR_MSB:`FINISH_THR_LSB];
      finish_timer_duration_o <= finish_reg[`FINISH_TIME_MSB:`FINISH_TIME_LSB];
      finish_timer_enable_o <= (finish_reg[`FINISH_TIME_MSB:`FINISH_TIME_LSB] != 3'h7);
    end
  end
endmodule // charger_control_registers

/* verif/charger_control_chk.sv */
// Port assertions for the charger control register bank.
`timescale 1ns/1ns
module charger_control_chk (
  input wire ref_clk_i, // Clock.
  input wire srst_i, // Reset.
  input wire wr_en_i, // Write strobe.
  input wire [7:0] addr_i, // Address.
  input wire [7:0] wdata_i, // Write data.
  input wire charger_enable_i, // Charging on.
  input wire charger_input_supply_i, // Input valid.
  input wire settings_unlocked_o, // Unlocked.
  input wire buck_enable_o, // Buck on.
  input wire temperature_profile_enable_o, // Profile on.
  input wire thermistor_enable_o, // Thermistor on.
  input wire ldo_enable_o, // Regulator on.
  input wire [4:0] fast_charge_current_code_o, // Current code.
  input wire [2:0] fast_charge_timeout_o, // Timeout code.
  input wire fast_charge_timer_enable_o, // Timer on.
  input wire [2:0] finish_current_threshold_o, // Finish threshold.
  input wire [2:0] finish_timer_duration_o, // Finish code.
  input wire finish_timer_enable_o // Finish timer on.
);
  // Decoded outputs follow a control write two edges later.
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_wr37;
    wr_en_i && addr_i == 8'h37;
  endsequence
  AST_UNLOCK: assert property (s_wr37 ##0 wdata_i[1:0] == 2'h3 |-> ##2 settings_unlocked_o)
    else $error("key 11 did not unlock");
  AST_LOCK: assert property (s_wr37 ##0 wdata_i[1:0] != 2'h3 |-> ##2 !settings_unlocked_o)
    else $error("other key did not lock");
  // A protected write only counts when the lock state that it met was open, seen one edge later.
  AST_HOLD: assert property (!($past(wr_en_i, 2) && $past(addr_i, 2) == 8'h38 && $past(settings_unlocked_o))
    |-> $stable(fast_charge_timeout_o))
    else $error("timeout changed without an accepted write");
  AST_HOLD_FIN: assert property (!($past(wr_en_i, 2) && $past(addr_i, 2) == 8'h39 && $past(settings_unlocked_o))
    |-> $stable({finish_timer_duration_o, finish_current_threshold_o}))
    else $error("finish settings changed without an accepted write");
  AST_BUCK: assert property (s_wr37 |-> ##2 buck_enable_o == $past(wdata_i[2], 2))
    else $error("buck enable wrong");
  AST_PROFILE: assert property (s_wr37 |-> ##2 temperature_profile_enable_o != $past(wdata_i[3], 2))
    else $error("profile sense wrong");
  AST_THERM: assert property (s_wr37 |-> ##2 thermistor_enable_o != $past(wdata_i[4], 2))
    else $error("thermistor sense wrong");
  AST_GATE: assert property (!charger_enable_i |=> fast_charge_current_code_o == 5'h00)
    else $error("current code not gated");
  AST_FCT: assert property (fast_charge_timer_enable_o == (fast_charge_timeout_o != 3'h0))
    else $error("timeout enable wrong");
  AST_FIN: assert property (finish_timer_enable_o == (finish_timer_duration_o != 3'h7))
    else $error("finish enable wrong");
  AST_RISE: assert property (charger_input_supply_i [*8] |=> ldo_enable_o)
    else $error("regulator late on rise");
endmodule // charger_control_chk
bind charger_control_registers charger_control_chk i_charger_control_chk (.*);

/* verif/tb_charger_control_registers.sv */
// Self-checking bench for the charger control register bank.
`timescale 1ns/1ns
`include "charger_control_defines.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_charger_control_registers;
  logic ref_clk_i = 0, srst_i = 1, wr_en_i = 0, rd_en_i = 0, charger_enable_i = 1, charger_input_supply_i = 0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
  wire [7:0] rdata_o;
  wire [4:0] fast_charge_current_code_o;
  wire [2:0] fast_charge_timeout_o, finish_current_threshold_o, finish_timer_duration_o;
  wire rvalid_o, settings_unlocked_o, buck_enable_o, temperature_profile_enable_o, thermistor_enable_o;
  wire ldo_enable_o, fast_charge_timer_enable_o, finish_timer_enable_o;
  int failures = 0, samples_checked = 0;
  // Rows: address, write data, expected read back.
  logic [23:0] rows [9] = '{24'h374747, 24'h38FFFF, 24'h39FFE7, 24'h382121, 24'h391A02, 24'h37A8A8, 24'h385521,
    24'h39FF02, 24'h3A1200};
  charger_control_registers i_charger_control_registers (.*);
  // Clock at 25 MHz.
  always #20 ref_clk_i = ~ref_clk_i;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rvalid_o)
    `CHK("rdata", e, rdata_o)
  endtask
  task w2;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog cuts a hang short.
  initial begin
    #(40 * 20000);
    failures++;
    report_and_stop;
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    w2;
    `CHK("unlocked", 1'b0, settings_unlocked_o)
    `CHK("buck", 1'b0, buck_enable_o)
    `CHK("profile", 1'b0, temperature_profile_enable_o)
    `CHK("therm", 1'b1, thermistor_enable_o)
    $display("table test done");
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd(8'h37, `CHG_CTRL_ONE_RESET);
    rd(8'h38, `FAST_CHG_RESET);
    rd(8'h39, `FINISH_CTRL_RESET);
    `CHK("buck rst", 1'b1, buck_enable_o)
    `CHK("lock rst", 1'b0, settings_unlocked_o)
    $display("reset test done");
    wr(8'h37, 8'h07);
    for (int c = 0; c < 8; c++) begin
      wr(8'h38, {c[2:0], 5'h1F});
      wr(8'h39, {c[2:0], 2'h0, c[2:0]});
      w2;
      `CHK("timeout", c[2:0], fast_charge_timeout_o)
      `CHK("fct en", c != 0, fast_charge_timer_enable_o)
      `CHK("code", 5'h1F, fast_charge_current_code_o)
      `CHK("thr", c[2:0], finish_current_threshold_o)
      `CHK("fin en", c != 7, finish_timer_enable_o)
      `CHK("fin dur", c[2:0], finish_timer_duration_o)
    end
    @(posedge ref_clk_i);
    charger_enable_i <= 1'b0;
    w2;
    `CHK("code off", 5'h00, fast_charge_current_code_o)
    $display("code test done");
    @(posedge ref_clk_i);
    charger_input_supply_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    `CHK("ldo rise", 1'b1, ldo_enable_o)
    charger_input_supply_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    `CHK("ldo fall", 1'b0, ldo_enable_o)
    charger_input_supply_i <= 1'b1;
    wr(8'h37, 8'h27);
    charger_input_supply_i <= 1'b0;
    repeat (1000) @(posedge ref_clk_i);
    `CHK("ldo dip", 1'b1, ldo_enable_o)
    charger_input_supply_i <= 1'b1;
    $display("regulator test done");
    report_and_stop;
  end
endmodule // tb_charger_control_registers
